// ===== dv/dfc_coder_assertions.sv
// Purpose: Port-level checks of the DC-free payload coder.
// Assumes: One clock and a synchronous active-high reset.
// Notes: Bound to every instance of the coder.
`timescale 1ns/1ps
module dfc_coder_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic [6:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic txStart,
  input wire logic txReady,
  input wire logic txBusy,
  input wire logic txDone,
  input wire logic rxChipValid,
  input wire logic rxValid,
  input wire logic rxDone,
  input wire logic rxCrcOk,
  input wire logic rxCodeErr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // A write to the high rate byte followed by a plain read of it.
  sequence hiWriteRead;
    regWrite && regAddr == 7'h03 ##1 !regWrite && regAddr == 7'h03;
  endsequence
  // A chip strobe in one of the two cycles before.
  sequence chipSeen;
    $past(rxChipValid) || $past(rxChipValid, 2);
  endsequence
  // Register, frame and byte timing at the ports.
  a_rate_readback: assert property (hiWriteRead |=> regRdata == $past(regWdata, 2))
    else $error("rate byte read back differs");
  a_unmapped_zero: assert property (regAddr != 7'h03 && regAddr != 7'h04 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_start_busy: assert property (txStart && !txBusy |=> txBusy)
    else $error("frame did not start");
  a_ready_in_frame: assert property (txReady |-> txBusy)
    else $error("byte request outside frame");
  a_done_pulse: assert property (txDone |-> $past(txBusy) ##1 !txDone)
    else $error("bad frame end pulse");
  a_byte_after_chip: assert property (rxValid |-> chipSeen)
    else $error("byte without chip");
  a_byte_single: assert property (rxValid |=> !rxValid)
    else $error("byte strobe too long");
  a_crc_at_done: assert property ($changed(rxCrcOk) |-> rxDone)
    else $error("check flag moved off frame end");
  a_code_err_cause: assert property ($rose(rxCodeErr) |-> chipSeen)
    else $error("code error without chip");
endmodule
bind dfc_coder dfc_coder_assertions chk (.clk, .reset, .regAddr, .regWrite, .regWdata, .regRdata, .txStart,
  .txReady, .txBusy, .txDone, .rxChipValid, .rxValid, .rxDone, .rxCrcOk, .rxCodeErr);

// ===== dv/dfc_line_model.sv
// Purpose: Modulator and demodulator side of the coder's chip stream.
// Assumes: Chips are handed in by the bench in line order.
// Notes: Between strobes the receive line shows the inverse chip.
`timescale 1ns/1ps
module dfc_line_model (
  input wire logic clk,
  input wire logic txChip,
  input wire logic txBusy,
  output logic rxChip,
  output logic rxChipValid
);
  logic cap[$];
  logic wasBusy = 1'b0;
  initial begin
    rxChip = 1'b0;
    rxChipValid = 1'b0;
  end
  // Records the settled transmit line once a cycle during a frame and in the cycle after it.
  // The last chip is launched on the edge that ends the frame, so it first stands in that cycle.
  always @(negedge clk) begin
    if (txBusy === 1'b1 || wasBusy) cap.push_back(txChip);
    wasBusy = (txBusy === 1'b1);
  end
  // Sends chips with gap idle cycles between strobes.
  task automatic send(input logic c[$], input int gap);
    foreach (c[i]) begin
      @(negedge clk);
      rxChip = c[i];
      rxChipValid = 1'b1;
      if (gap > 0) begin
        @(negedge clk);
        rxChipValid = 1'b0;
        rxChip = ~c[i];
        repeat (gap - 1) @(negedge clk);
      end
    end
    @(negedge clk);
    rxChipValid = 1'b0;
    rxChip = ~c[c.size() - 1];
  endtask
endmodule

// ===== dv/testbench.sv
// Purpose: Self-checking bench of the DC-free payload coder.
// Assumes: Chip period is set to P clocks through the rate bytes.
// Notes: Expected chips are built here bit by bit.
`timescale 1ns/1ps
module testbench;
  localparam int P = 3;
  logic clk, reset, regWrite, packetMode, txStart, txValid, txReady, txChip, txBusy, txDone;
  logic rxStart, rxChip, rxChipValid, rxValid, rxDone, rxCrcOk, rxCodeErr;
  logic [6:0] regAddr;
  logic [1:0] dcFreeSelect;
  logic [7:0] regWdata, regRdata, txHeadBytes, txPayBytes, txData, rxPayBytes, rxData;
  int numErrors;
  int nChecks;
  logic ex[$];
  logic [8:0] lf;
  logic [15:0] crc;

  dfc_coder dut (.clk, .reset, .regAddr, .regWrite, .regWdata, .regRdata, .dcFreeSelect, .packetMode,
    .txStart, .txHeadBytes, .txPayBytes, .txData, .txValid, .txReady, .txChip, .txBusy, .txDone,
    .rxStart, .rxPayBytes, .rxChip, .rxChipValid, .rxData, .rxValid, .rxDone, .rxCrcOk, .rxCodeErr);
  dfc_line_model line (.clk, .txChip, .txBusy, .rxChip, .rxChipValid);

  // Clock of 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    nChecks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      numErrors++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic [7:0] pay(input int k);
    return 8'(k * 29 + 60);
  endfunction

  // Codes one byte, MSB first, into the expected chip list.
  task automatic add_byte(input logic [7:0] b, input logic [1:0] m, input bit upd);
    logic d;
    for (int i = 7; i >= 0; i--) begin
      d = b[i];
      if (upd) crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ d) ? dfc_pkg::CRC_POLY : 16'h0000);
      if (m == dfc_pkg::DCF_WHITE) begin
        d = d ^ lf[0];
        lf = {lf[0] ^ lf[dfc_pkg::LFSR_TAP], lf[8:1]};
      end
      ex.push_back(d);
      if (m == dfc_pkg::DCF_MANCH) ex.push_back(~d);
    end
  endtask

  // Payload then checksum high and low byte, all coded.
  task automatic build(input logic [1:0] m, input int np);
    logic [15:0] c;
    lf = dfc_pkg::LFSR_SEED;
    crc = dfc_pkg::CRC_INIT;
    for (int k = 0; k < np; k++) add_byte(pay(k), m, 1'b1);
    c = crc;
    add_byte(c[15:8], m, 1'b0);
    add_byte(c[7:0], m, 1'b0);
  endtask

  task automatic reg_rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge clk);
    regAddr = a;
    @(negedge clk);
    chk("register", {8'h00, e}, {8'h00, regRdata});
  endtask

  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
  endtask

  // Sends two plain header bytes and three payload bytes, then finds the chips on the line.
  task automatic run_tx(input logic [1:0] sel, input logic pm);
    int k;
    int t;
    int n;
    bit hit;
    ex.delete();
    line.cap.delete();
    repeat (2) add_byte(8'hC5, dfc_pkg::DCF_NONE, 1'b0);
    build((sel == dfc_pkg::DCF_MANCH && !pm) ? dfc_pkg::DCF_NONE : sel, 3);
    @(negedge clk);
    dcFreeSelect = sel;
    packetMode = pm;
    txHeadBytes = 8'h02;
    txPayBytes = 8'h03;
    txStart = 1'b1;
    k = 0;
    for (t = 0; t < 2000 && txDone !== 1'b1; t++) begin
      @(negedge clk);
      txStart = 1'b0;
      txValid = k < 5;
      txData = k < 2 ? 8'hC5 : pay(k - 2);
      if (txValid && txReady === 1'b1) k++;
    end
    @(negedge clk);
    txValid = 1'b0;
    if (t == 2000) begin
      numErrors++;
      tally_and_finish();
    end
    n = ex.size() * P - P + 1;
    hit = 1'b0;
    for (int o = 0; o < 2 * P + 4 && !hit; o++) begin
      hit = o + n <= line.cap.size();
      for (int i = 0; i < n && hit; i++) hit = line.cap[o + i] === ex[i / P];
    end
    chk("tx chips", 16'h0001, {15'h0000, hit});
  endtask

  // Feeds four coded payload bytes and checksum; bad corrupts one chip.
  task automatic run_rx(input logic [1:0] sel, input int gap, input bit bad, input logic pm);
    int k;
    int t;
    int i;
    logic [1:0] m;
    m = (sel == dfc_pkg::DCF_MANCH && !pm) ? dfc_pkg::DCF_NONE : sel;
    ex.delete();
    build(m, 4);
    i = m == dfc_pkg::DCF_MANCH ? 1 : ex.size() - 1;
    if (bad) ex[i] = ~ex[i];
    @(negedge clk);
    dcFreeSelect = sel;
    packetMode = pm;
    rxPayBytes = 8'h04;
    rxStart = 1'b1;
    @(negedge clk);
    rxStart = 1'b0;
    fork
      line.send(ex, gap);
    join_none
    k = 0;
    for (t = 0; t < 3000 && rxDone !== 1'b1; t++) begin
      @(negedge clk);
      if (rxValid === 1'b1) begin
        chk("rx byte", {8'h00, pay(k)}, {8'h00, rxData});
        k++;
      end
    end
    if (t == 3000) begin
      numErrors++;
      tally_and_finish();
    end
    wait fork;
    chk("rx count", 16'h0004, 16'(k));
    chk("crc ok", {15'h0000, !(bad && i > 1)}, {15'h0000, rxCrcOk});
    chk("code err", {15'h0000, bad && i == 1}, {15'h0000, rxCodeErr});
  endtask

  // Main sequence.
  initial begin
    reset = 1'b1;
    {regAddr, regWrite, regWdata, dcFreeSelect, packetMode, txStart} = '0;
    {txHeadBytes, txPayBytes, txData, txValid, rxStart, rxPayBytes} = '0;
    numErrors = 0;
    nChecks = 0;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    reg_rd(dfc_pkg::REG_RATE_HI, dfc_pkg::RATE_HI_RST);
    reg_rd(dfc_pkg::REG_RATE_LO, dfc_pkg::RATE_LO_RST);
    reg_wr(7'h05, 8'h5A);
    reg_rd(7'h05, 8'h00);
    reg_wr(dfc_pkg::REG_RATE_HI, 8'h00);
    reg_rd(dfc_pkg::REG_RATE_HI, 8'h00);
    reg_wr(dfc_pkg::REG_RATE_LO, 8'(P));
    reg_rd(dfc_pkg::REG_RATE_LO, 8'(P));
    for (int s = 0; s < 4; s++) run_tx(2'(s), 1'b1);
    run_tx(dfc_pkg::DCF_MANCH, 1'b0);
    for (int s = 0; s < 4; s++) run_rx(2'(s), s, 1'b0, 1'b1);
    run_rx(dfc_pkg::DCF_MANCH, 1, 1'b0, 1'b0);
    run_rx(dfc_pkg::DCF_WHITE, 1, 1'b1, 1'b1);
    run_rx(dfc_pkg::DCF_MANCH, 0, 1'b1, 1'b1);
    tally_and_finish();
  end
endmodule

// ===== inc/dfc_lfsr_if.sv
// Purpose: Carries seed, step and sequence bit between the coder and a whitening generator.
// Assumes: seed and step are single-cycle requests from the coder.
// Notes: wbit is the current sequence bit, valid in every cycle.
`timescale 1ns/1ps
interface dfc_lfsr_if;
  logic seed;
  logic step;
  logic wbit;
  modport gen (input seed, input step, output wbit);
  modport user (output seed, output step, input wbit);
endinterface

// ===== inc/dfc_pkg.sv
// Purpose: Shared constants, states and the CRC step for the DC-free payload coder.
// Assumes: One 10 MHz clock; register addresses are the device's 7-bit register addresses.
// Notes: The CRC start value and the chip-rate reset values are kept here so both ends agree.
package dfc_pkg;

  // Register addresses and their reset values.
  localparam logic [6:0] REG_RATE_HI = 7'h03;
  localparam logic [6:0] REG_RATE_LO = 7'h04;
  localparam logic [7:0] RATE_HI_RST = 8'h1A;
  localparam logic [7:0] RATE_LO_RST = 8'h0B;

  // Encodings of the DC-free select field.
  localparam logic [1:0] DCF_NONE = 2'h0;
  localparam logic [1:0] DCF_MANCH = 2'h1;
  localparam logic [1:0] DCF_WHITE = 2'h2;

  // Whitening generator: x^9 + x^5 + 1, seeded with all ones.
  localparam int LFSR_W = 9;
  localparam int LFSR_TAP = 5;
  localparam logic [8:0] LFSR_SEED = 9'h1FF;

  // Two-byte CCITT checksum.
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;

  // Clock rate of the block.
  localparam int CLK_HZ = 10000000;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_HEAD = 4'h2,
    TX_PAY = 4'h4,
    TX_CRC = 4'h8
  } dfc_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h1,
    RX_PAY = 3'h2,
    RX_CRC = 3'h4
  } dfc_rx_e;

  // Advances the checksum by one data bit, most significant bit first.
  function automatic logic [15:0] dfc_crc_bit(input logic [15:0] crc, input logic din);
    logic fb;
    fb = crc[15] ^ din;
    dfc_crc_bit = {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
  endfunction

endpackage

// ===== verilog/dfc_coder.sv
// Purpose: Line coding of payload and checksum with Manchester (in packet mode only) or whitening, transmit and receive.
// Assumes: Packet engine supplies header bytes then payload bytes; demodulator strobes each chip.
// Notes: Register port is the device's 7-bit register address port; reads return a cycle later.
`timescale 1ns/1ps
module dfc_coder (
  input wire logic clk,
  input wire logic reset,
  input wire logic [6:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic [1:0] dcFreeSelect,
  input wire logic packetMode,
  input wire logic txStart,
  input wire logic [7:0] txHeadBytes,
  input wire logic [7:0] txPayBytes,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic txChip,
  output logic txBusy,
  output logic txDone,
  input wire logic rxStart,
  input wire logic [7:0] rxPayBytes,
  input wire logic rxChip,
  input wire logic rxChipValid,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxDone,
  output logic rxCrcOk,
  output logic rxCodeErr
);

  // Register file and read port.
  logic [7:0] rateHi_q;
  logic [7:0] rateLo_q;
  logic [7:0] regRdata_q;
  logic [7:0] readMux;
  logic [15:0] rate;
  logic [15:0] rateM1;

  assign readMux = (regAddr == dfc_pkg::REG_RATE_HI) ? rateHi_q :
                   (regAddr == dfc_pkg::REG_RATE_LO) ? rateLo_q : 8'h00;
  assign rate = {rateHi_q, rateLo_q};
  assign rateM1 = (rate == 16'h0000) ? 16'h0000 : rate - 16'h0001;
  assign regRdata = regRdata_q;

  // Holds the chip-rate setting and answers reads.
  always_ff @(posedge clk) begin
    if (reset) begin
      rateHi_q <= dfc_pkg::RATE_HI_RST;
      rateLo_q <= dfc_pkg::RATE_LO_RST;
      regRdata_q <= 8'h00;
    end else begin
      if (regWrite && regAddr == dfc_pkg::REG_RATE_HI) rateHi_q <= regWdata;
      if (regWrite && regAddr == dfc_pkg::REG_RATE_LO) rateLo_q <= regWdata;
      regRdata_q <= readMux;
    end
  end

  // Transmit state.
  dfc_pkg::dfc_tx_e txSt_q, txSt_d;
  logic [7:0] txCnt_q, txCnt_d;
  logic [7:0] txPay_q;
  logic [7:0] txSh_q, txSh_d;
  logic txHave_q, txHave_d;
  logic txHalf_q, txHalf_d;
  logic [2:0] txBit_q, txBit_d;
  logic txChip_q, txChip_d;
  logic txDone_q, txDone_d;
  logic txReady_q, txReady_d;
  logic txBusy_q;
  logic [15:0] txCrc_q, txCrc_d;
  logic txCrcIdx_q, txCrcIdx_d;
  logic txManOn_q;
  logic txWhtOn_q;
  logic [15:0] div_q;
  logic chipTick;
  logic txStartOk;
  logic txTake;
  logic txInBody;
  logic txMan;
  logic txWht;
  logic txCoded;
  logic txEmit;
  logic txBitDone;
  logic txByteDone;
  logic [15:0] txCrcNext;
  logic [15:0] txCrcNow;
  dfc_lfsr_if txLf ();

  assign txStartOk = txStart && (txSt_q == dfc_pkg::TX_IDLE);
  assign txTake = txValid && txReady_q;
  assign txInBody = (txSt_q == dfc_pkg::TX_PAY) || (txSt_q == dfc_pkg::TX_CRC);
  assign txMan = txManOn_q && txInBody;
  assign txWht = txWhtOn_q && txInBody;
  assign txCoded = txWht ? (txSh_q[7] ^ txLf.wbit) : txSh_q[7];
  assign chipTick = (div_q == 16'h0000) && (txSt_q != dfc_pkg::TX_IDLE);
  assign txEmit = chipTick && txHave_q;
  assign txBitDone = txEmit && (!txMan || txHalf_q);
  assign txByteDone = txBitDone && (txBit_q == 3'h7);
  assign txCrcNext = dfc_pkg::dfc_crc_bit(txCrc_q, txSh_q[7]);
  assign txCrcNow = (txSt_q == dfc_pkg::TX_PAY) ? txCrcNext : txCrc_q;
  assign txLf.seed = txStartOk;
  assign txLf.step = txBitDone && txWht;
  assign txReady = txReady_q;
  assign txChip = txChip_q;
  assign txBusy = txBusy_q;
  assign txDone = txDone_q;

  dfc_lfsr txGen (
    .clk(clk),
    .reset(reset),
    .lf(txLf)
  );

  // Next state of the transmit serialiser.
  always_comb begin
    txSt_d = txSt_q;
    txCnt_d = txCnt_q;
    txSh_d = txSh_q;
    txHave_d = txHave_q;
    txHalf_d = txHalf_q;
    txBit_d = txBit_q;
    txChip_d = txChip_q;
    txDone_d = 1'b0;
    txCrc_d = txCrc_q;
    txCrcIdx_d = txCrcIdx_q;
    if (txStartOk) begin
      txHalf_d = 1'b0;
      txBit_d = 3'h0;
      txHave_d = 1'b0;
      txCrc_d = dfc_pkg::CRC_INIT;
      txCrcIdx_d = 1'b0;
      if (txHeadBytes != 8'h00) begin
        txSt_d = dfc_pkg::TX_HEAD;
        txCnt_d = txHeadBytes;
      end else if (txPayBytes != 8'h00) begin
        txSt_d = dfc_pkg::TX_PAY;
        txCnt_d = txPayBytes;
      end else begin
        txSt_d = dfc_pkg::TX_CRC;
        txSh_d = dfc_pkg::CRC_INIT[15:8];
        txHave_d = 1'b1;
      end
    end else begin
      if (txTake) begin
        txSh_d = txData;
        txHave_d = 1'b1;
      end
      if (txEmit) begin
        txChip_d = (txMan && txHalf_q) ? ~txCoded : txCoded;
        txHalf_d = txMan && !txHalf_q;
      end
      if (txBitDone) begin
        txSh_d = {txSh_q[6:0], 1'b0};
        txBit_d = txBit_q + 3'h1;
        if (txSt_q == dfc_pkg::TX_PAY) txCrc_d = txCrcNext;
      end
      if (txByteDone) begin
        txHave_d = 1'b0;
        case (txSt_q)
          dfc_pkg::TX_HEAD: begin
            if (txCnt_q != 8'h01) begin
              txCnt_d = txCnt_q - 8'h01;
            end else if (txPay_q != 8'h00) begin
              txSt_d = dfc_pkg::TX_PAY;
              txCnt_d = txPay_q;
            end else begin
              txSt_d = dfc_pkg::TX_CRC;
              txSh_d = txCrcNow[15:8];
              txHave_d = 1'b1;
            end
          end
          dfc_pkg::TX_PAY: begin
            if (txCnt_q != 8'h01) begin
              txCnt_d = txCnt_q - 8'h01;
            end else begin
              txSt_d = dfc_pkg::TX_CRC;
              txSh_d = txCrcNow[15:8];
              txHave_d = 1'b1;
            end
          end
          dfc_pkg::TX_CRC: begin
            if (!txCrcIdx_q) begin
              txSh_d = txCrc_q[7:0];
              txHave_d = 1'b1;
              txCrcIdx_d = 1'b1;
            end else begin
              txSt_d = dfc_pkg::TX_IDLE;
              txDone_d = 1'b1;
            end
          end
          default: begin
            txSt_d = dfc_pkg::TX_IDLE;
          end
        endcase
      end
    end
    txReady_d = ((txSt_d == dfc_pkg::TX_HEAD) || (txSt_d == dfc_pkg::TX_PAY)) && !txHave_d;
  end

  // Transmit registers and the chip-rate divider, restarted at each frame.
  always_ff @(posedge clk) begin
    if (reset) begin
      txSt_q <= dfc_pkg::TX_IDLE;
      txCnt_q <= 8'h00;
      txPay_q <= 8'h00;
      txSh_q <= 8'h00;
      txHave_q <= 1'b0;
      txHalf_q <= 1'b0;
      txBit_q <= 3'h0;
      txChip_q <= 1'b0;
      txDone_q <= 1'b0;
      txReady_q <= 1'b0;
      txBusy_q <= 1'b0;
      txCrc_q <= dfc_pkg::CRC_INIT;
      txCrcIdx_q <= 1'b0;
      txManOn_q <= 1'b0;
      txWhtOn_q <= 1'b0;
      div_q <= 16'h0000;
    end else begin
      txSt_q <= txSt_d;
      txCnt_q <= txCnt_d;
      txSh_q <= txSh_d;
      txHave_q <= txHave_d;
      txHalf_q <= txHalf_d;
      txBit_q <= txBit_d;
      txChip_q <= txChip_d;
      txDone_q <= txDone_d;
      txReady_q <= txReady_d;
      txBusy_q <= (txSt_d != dfc_pkg::TX_IDLE); // Busy follows the state register, but from a flop of its own.
      txCrc_q <= txCrc_d;
      txCrcIdx_q <= txCrcIdx_d;
      div_q <= (txStartOk || div_q == 16'h0000) ? rateM1 : div_q - 16'h0001;
      if (txStartOk) begin
        txPay_q <= txPayBytes;
        txManOn_q <= packetMode && (dcFreeSelect == dfc_pkg::DCF_MANCH);
        txWhtOn_q <= (dcFreeSelect == dfc_pkg::DCF_WHITE);
      end
    end
  end

  // Receive state.
  dfc_pkg::dfc_rx_e rxSt_q, rxSt_d;
  logic [7:0] rxCnt_q, rxCnt_d;
  logic [7:0] rxSh_q;
  logic [2:0] rxBit_q;
  logic rxHalf_q;
  logic rxFirst_q;
  logic [15:0] rxCrc_q, rxCrc_d;
  logic [7:0] rxCrcHi_q;
  logic rxCrcIdx_q;
  logic rxManOn_q;
  logic rxWhtOn_q;
  logic [7:0] rxData_q;
  logic rxValid_q, rxDone_q, rxCrcOk_q, rxCodeErr_q;
  logic rxValid_d, rxDone_d, rxCrcOk_d;
  logic rxStartOk;
  logic rxActive;
  logic rxBitDone;
  logic rxRaw;
  logic rxBitVal;
  logic rxByteDone;
  logic [7:0] rxByte;
  logic rxPairBad;
  dfc_lfsr_if rxLf ();

  assign rxStartOk = rxStart && (rxSt_q == dfc_pkg::RX_IDLE);
  assign rxActive = (rxSt_q != dfc_pkg::RX_IDLE) && rxChipValid;
  assign rxBitDone = rxActive && (!rxManOn_q || rxHalf_q);
  assign rxRaw = rxManOn_q ? rxFirst_q : rxChip;
  assign rxPairBad = rxManOn_q && rxHalf_q && rxActive && (rxFirst_q == rxChip);
  assign rxBitVal = rxWhtOn_q ? (rxRaw ^ rxLf.wbit) : rxRaw;
  assign rxByte = {rxSh_q[6:0], rxBitVal};
  assign rxByteDone = rxBitDone && (rxBit_q == 3'h7);
  assign rxLf.seed = rxStartOk;
  assign rxLf.step = rxBitDone && rxWhtOn_q;
  assign rxData = rxData_q;
  assign rxValid = rxValid_q;
  assign rxDone = rxDone_q;
  assign rxCrcOk = rxCrcOk_q;
  assign rxCodeErr = rxCodeErr_q;

  dfc_lfsr rxGen (
    .clk(clk),
    .reset(reset),
    .lf(rxLf)
  );

  // Next state of the receive deserialiser and checksum stripper.
  always_comb begin
    rxSt_d = rxSt_q;
    rxCnt_d = rxCnt_q;
    rxCrc_d = rxCrc_q;
    rxValid_d = 1'b0;
    rxDone_d = 1'b0;
    rxCrcOk_d = rxCrcOk_q;
    if (rxStartOk) begin
      rxSt_d = (rxPayBytes != 8'h00) ? dfc_pkg::RX_PAY : dfc_pkg::RX_CRC;
      rxCnt_d = rxPayBytes;
      rxCrc_d = dfc_pkg::CRC_INIT;
    end else begin
      if (rxBitDone && rxSt_q == dfc_pkg::RX_PAY) rxCrc_d = dfc_pkg::dfc_crc_bit(rxCrc_q, rxBitVal);
      if (rxByteDone) begin
        case (rxSt_q)
          dfc_pkg::RX_PAY: begin
            rxValid_d = 1'b1;
            rxCnt_d = rxCnt_q - 8'h01;
            if (rxCnt_q == 8'h01) rxSt_d = dfc_pkg::RX_CRC;
          end
          dfc_pkg::RX_CRC: begin
            if (rxCrcIdx_q) begin
              rxSt_d = dfc_pkg::RX_IDLE;
              rxDone_d = 1'b1;
              rxCrcOk_d = ({rxCrcHi_q, rxByte} == rxCrc_q);
            end
          end
          default: begin
            rxSt_d = dfc_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  // Receive registers; checksum bytes never reach the FIFO side.
  always_ff @(posedge clk) begin
    if (reset) begin
      rxSt_q <= dfc_pkg::RX_IDLE;
      rxCnt_q <= 8'h00;
      rxSh_q <= 8'h00;
      rxBit_q <= 3'h0;
      rxHalf_q <= 1'b0;
      rxFirst_q <= 1'b0;
      rxCrc_q <= dfc_pkg::CRC_INIT;
      rxCrcHi_q <= 8'h00;
      rxCrcIdx_q <= 1'b0;
      rxManOn_q <= 1'b0;
      rxWhtOn_q <= 1'b0;
      rxData_q <= 8'h00;
      rxValid_q <= 1'b0;
      rxDone_q <= 1'b0;
      rxCrcOk_q <= 1'b0;
      rxCodeErr_q <= 1'b0;
    end else begin
      rxSt_q <= rxSt_d;
      rxCnt_q <= rxCnt_d;
      rxCrc_q <= rxCrc_d;
      rxValid_q <= rxValid_d;
      rxDone_q <= rxDone_d;
      rxCrcOk_q <= rxCrcOk_d;
      if (rxStartOk) begin
        rxBit_q <= 3'h0;
        rxHalf_q <= 1'b0;
        rxCrcIdx_q <= 1'b0;
        rxCodeErr_q <= 1'b0;
        rxManOn_q <= packetMode && (dcFreeSelect == dfc_pkg::DCF_MANCH);
        rxWhtOn_q <= (dcFreeSelect == dfc_pkg::DCF_WHITE);
      end else begin
        if (rxActive && rxManOn_q) rxHalf_q <= !rxHalf_q;
        if (rxActive && !rxHalf_q) rxFirst_q <= rxChip;
        if (rxPairBad) rxCodeErr_q <= 1'b1;
        if (rxBitDone) begin
          rxSh_q <= rxByte;
          rxBit_q <= rxBit_q + 3'h1;
        end
        if (rxByteDone && rxSt_q == dfc_pkg::RX_PAY) rxData_q <= rxByte;
        if (rxByteDone && rxSt_q == dfc_pkg::RX_CRC) begin
          rxCrcHi_q <= rxByte;
          rxCrcIdx_q <= 1'b1;
        end
      end
    end
  end

endmodule

// ===== verilog/dfc_lfsr.sv
// Purpose: Nine-bit whitening sequence generator.
// Assumes: seed wins over step when both are raised.
// Notes: One step per data bit; the low bit is the sequence bit.
`timescale 1ns/1ps
module dfc_lfsr (
  input wire logic clk,
  input wire logic reset,
  dfc_lfsr_if.gen lf
);

  logic [dfc_pkg::LFSR_W-1:0] state_q;
  logic feedback;

  // Feedback taps of x^9 + x^5 + 1.
  assign feedback = state_q[0] ^ state_q[dfc_pkg::LFSR_TAP];
  assign lf.wbit = state_q[0];

  // Reseed at each packet and shift once per data bit.
  always_ff @(posedge clk) begin
    if (reset || lf.seed) begin
      state_q <= dfc_pkg::LFSR_SEED;
    end else if (lf.step) begin
      state_q <= {feedback, state_q[dfc_pkg::LFSR_W-1:1]};
    end
  end

endmodule
